/* File: verilog/memory_space_map.vh */
// Purpose: constants for the memory space decoder
// Assumes: byte wide register file and program memory
// Notes: included by every file of the decoder
`ifndef MEMORY_SPACE_MAP_VH
`define MEMORY_SPACE_MAP_VH

// register file space
`define RF_ADDR_W 12
`define RF_SPACE_BYTES 4096
`define RAM_BASE 12'h000
`define CTRL_BASE 12'hf00
`define CTRL_LAST 12'hfff
`define CTRL_BYTES 256
`define RAM_SIZE_MIN 2048
`define RAM_SIZE_MAX 4096
`define PAGE_SELECT_ADDR 12'hffd
`define PAGE_SELECT_RESET 8'h00
`define INFO_ENABLE_BIT 7

// program memory space
`define PM_ADDR_W 16
`define PM_SPACE_BYTES 65536
`define FLASH_SIZE_MIN 16384
`define FLASH_SIZE_MAX 65536
`define INFO_BASE 16'hfe00
`define INFO_LAST 16'hffff
`define INFO_BYTES 512
`define INFO_OFFSET_W 9
`define PART_NUM_BASE 9'h040
`define PART_NUM_LEN 20
`define UNIMPL_FLASH_DATA 8'hff
`define UNDEF_DATA 8'h00

// program memory access kinds
`define PM_FETCH 2'h0
`define PM_LOAD 2'h1
`define PM_DEBUG 2'h2

// read data sources
`define SRC_UNDEF 2'h0
`define SRC_RAM 2'h1
`define SRC_PERIPH 2'h2
`define SRC_PAGE 2'h3
`define SRC_FILL 2'h0
`define SRC_FLASH 2'h1
`define SRC_INFO 2'h2

`endif

/* File: verilog/read_return_stage.v */
// Purpose: registers the read answer of one address space
// Assumes: sources present their data one cycle after the request
// Notes: valid stands for exactly one cycle, the answer holds until the next one
`timescale 1ns/1ps
`include "memory_space_map.vh"

module read_return_stage (
   input wire clock,
   input wire reset_n,
   input wire issue,
   input wire [1:0] sel,
   input wire [7:0] src0,
   input wire [7:0] src1,
   input wire [7:0] src2,
   input wire [7:0] src3,
   output reg [7:0] rdata,
   output reg rvalid
);

   reg pending;
   reg [1:0] sel_q;
   reg [7:0] next_rdata;

   always @* begin
      case (sel_q)
         2'h0: next_rdata = src0;
         2'h1: next_rdata = src1;
         2'h2: next_rdata = src2;
         2'h3: next_rdata = src3;
         default: next_rdata = `UNDEF_DATA;
      endcase
   end

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pending <= 1'b0;
         sel_q <= 2'h0;
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         pending <= issue;
         if (issue) begin
            sel_q <= sel;
         end
         rvalid <= pending;
         // data holds its last value between answers
         if (pending) begin
            rdata <= next_rdata;
         end
      end
   end

endmodule

/* File: verilog/info_area_rom.v */
// Purpose: read-only information area contents
// Assumes: offset is the low nine bits of a program memory address
// Notes: one cycle read latency, same as the flash array
`timescale 1ns/1ps
`include "memory_space_map.vh"

module info_area_rom #(
   // arbitrary part number, left-justified and zero filled
   parameter [159:0] PART_NUMBER = {"TESTPART", 96'h0}
) (
   input wire clock,
   input wire reset_n,
   input wire rd,
   input wire [8:0] offset,
   output reg [7:0] rdata
);

   wire [8:0] char_index = offset - `PART_NUM_BASE;
   wire in_part_number = (offset >= `PART_NUM_BASE) &&
                         (char_index < `PART_NUM_LEN);
   wire [159:0] shifted = PART_NUMBER << {char_index[4:0], 3'b000};

   // there is no write port at all, so the contents cannot change
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         // reserved bytes of the area read as zero
         rdata <= in_part_number ? shifted[159:152] : 8'h00;
      end
   end

endmodule

/* File: verilog/memory_space_decoder.v */
// Purpose: address decoder for the register file, program memory and data memory spaces
// Assumes: ram, flash and peripherals answer one cycle after a read strobe
// Notes: read answers arrive two edges after the request, from flip-flops
`timescale 1ns/1ps
`include "memory_space_map.vh"

module memory_space_decoder #(
   parameter integer RAM_SIZE = `RAM_SIZE_MAX,
   parameter integer FLASH_SIZE = `FLASH_SIZE_MAX,
   parameter [159:0] PART_NUMBER = {"TESTPART", 96'h0}
) (
   input wire clock,
   input wire reset_n,
   // register file requests from core or debugger
   input wire [11:0] rf_addr,
   input wire rf_rd,
   input wire rf_wr,
   input wire [7:0] rf_wdata,
   output wire [7:0] rf_rdata,
   output wire rf_rvalid,
   // on-chip ram
   output wire [11:0] ram_addr,
   output wire ram_rd,
   output wire ram_wr,
   output wire [7:0] ram_wdata,
   input wire [7:0] ram_rdata,
   // control register window
   output wire [7:0] periph_addr,
   output wire periph_rd,
   output wire periph_wr,
   output wire [7:0] periph_wdata,
   input wire [7:0] periph_rdata,
   // program memory requests
   input wire [15:0] pm_addr,
   input wire [1:0] pm_kind,
   input wire pm_rd,
   input wire pm_wr,
   input wire [7:0] pm_wdata,
   output wire [7:0] pm_rdata,
   output wire pm_rvalid,
   // on-chip flash
   output wire [15:0] flash_addr,
   output wire flash_rd,
   output wire flash_wr,
   output wire [7:0] flash_wdata,
   input wire [7:0] flash_rdata,
   // data memory requests
   input wire [15:0] dm_addr,
   input wire dm_rd,
   input wire dm_wr,
   output wire [7:0] dm_rdata,
   output wire dm_rvalid,
   // overlay state
   output wire info_enabled,
   output wire [7:0] page_select
);

   localparam [12:0] RAM_END = RAM_SIZE[12:0];
   localparam [16:0] FLASH_END = FLASH_SIZE[16:0];

   // register file region codes
   localparam [1:0] RF_RAM = 2'h0;
   localparam [1:0] RF_HOLE = 2'h1;
   localparam [1:0] RF_CTRL = 2'h2;

   // classify a register file address
   function [1:0] rf_region;
      input [11:0] addr;
      begin
         if (addr >= `CTRL_BASE) begin
            rf_region = RF_CTRL;
         end else if ({1'b0, addr} < RAM_END) begin
            rf_region = RF_RAM;
         end else begin
            rf_region = RF_HOLE;
         end
      end
   endfunction

   // flash exists from address zero up to the variant size
   function flash_present;
      input [15:0] addr;
      begin
         flash_present = ({1'b0, addr} < FLASH_END);
      end
   endfunction

   // true when the overlay applies to this address
   function in_info_window;
      input [15:0] addr;
      input enabled;
      begin
         in_info_window = enabled && (addr >= `INFO_BASE);
      end
   endfunction

   reg [7:0] page_select_reg;

   // register file decode
   wire [1:0] rf_kind = rf_region(rf_addr);
   wire rf_is_page = (rf_addr == `PAGE_SELECT_ADDR);
   wire rf_to_ram = (rf_kind == RF_RAM);
   wire rf_to_ctrl = (rf_kind == RF_CTRL) && !rf_is_page;

   assign ram_addr = rf_addr;
   assign ram_wdata = rf_wdata;
   assign ram_rd = rf_rd && rf_to_ram;
   // the gap between ram and the control window swallows writes
   assign ram_wr = rf_wr && rf_to_ram;

   assign periph_addr = rf_addr[7:0];
   assign periph_wdata = rf_wdata;
   // reserved control addresses go to the peripheral side unchanged;
   // what they return there is whatever that side drives
   assign periph_rd = rf_rd && rf_to_ctrl;
   assign periph_wr = rf_wr && rf_to_ctrl;

   reg [1:0] rf_sel;

   always @* begin
      case (rf_kind)
         RF_RAM: rf_sel = `SRC_RAM;
         RF_CTRL: rf_sel = rf_is_page ? `SRC_PAGE : `SRC_PERIPH;
         RF_HOLE: rf_sel = `SRC_UNDEF;
         default: rf_sel = `SRC_UNDEF;
      endcase
   end

   // page select lives here because the overlay depends on it
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         page_select_reg <= `PAGE_SELECT_RESET;
      end else if (rf_wr && rf_is_page) begin
         page_select_reg <= rf_wdata;
      end
   end

   assign page_select = page_select_reg;
   assign info_enabled = page_select_reg[`INFO_ENABLE_BIT];

   read_return_stage u_rf_return (
      .clock(clock),
      .reset_n(reset_n),
      .issue(rf_rd),
      .sel(rf_sel),
      .src0(`UNDEF_DATA),
      .src1(ram_rdata),
      .src2(periph_rdata),
      .src3(page_select_reg),
      .rdata(rf_rdata),
      .rvalid(rf_rvalid)
   );

   // program memory decode
   wire pm_in_flash = flash_present(pm_addr);
   wire pm_overlay = in_info_window(pm_addr, info_enabled);
   // fetches ignore the overlay so code in the top page keeps running
   wire pm_data_read = (pm_kind == `PM_LOAD) || (pm_kind == `PM_DEBUG);
   wire pm_use_info = pm_rd && pm_overlay && pm_data_read;
   wire pm_use_flash = pm_rd && pm_in_flash && !pm_use_info;

   assign flash_addr = pm_addr;
   assign flash_wdata = pm_wdata;
   assign flash_rd = pm_use_flash;
   // a write into the overlaid window is dropped entirely while the
   // overlay is on, since it can only have been aimed at the info area
   assign flash_wr = pm_wr && pm_in_flash && !pm_overlay;

   reg [1:0] pm_sel;

   always @* begin
      if (pm_use_info) begin
         pm_sel = `SRC_INFO;
      end else if (pm_in_flash) begin
         pm_sel = `SRC_FLASH;
      end else begin
         pm_sel = `SRC_FILL;
      end
   end

   wire [7:0] info_rdata;

   info_area_rom #(
      .PART_NUMBER(PART_NUMBER)
   ) u_info_rom (
      .clock(clock),
      .reset_n(reset_n),
      .rd(pm_use_info),
      .offset(pm_addr[8:0]),
      .rdata(info_rdata)
   );

   read_return_stage u_pm_return (
      .clock(clock),
      .reset_n(reset_n),
      .issue(pm_rd),
      .sel(pm_sel),
      .src0(`UNIMPL_FLASH_DATA),
      .src1(flash_rdata),
      .src2(info_rdata),
      .src3(`UNIMPL_FLASH_DATA),
      .rdata(pm_rdata),
      .rvalid(pm_rvalid)
   );

   // data memory space: nothing is decoded, writes vanish and reads
   // still get an answer so a stray access cannot hang the core
   wire dm_unused_addr = |dm_addr;
   wire dm_unused_wr = dm_wr;

   reg dm_pending;
   reg dm_answer_valid;
   reg [7:0] dm_answer;

   // a local two-stage answer keeps the timing of the other spaces
   // without a return stage whose every source is a constant
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dm_pending <= 1'b0;
         dm_answer_valid <= 1'b0;
         dm_answer <= `UNDEF_DATA;
      end else begin
         dm_pending <= dm_rd;
         dm_answer_valid <= dm_pending;
         if (dm_pending) begin
            dm_answer <= `UNDEF_DATA;
         end
      end
   end

   assign dm_rdata = dm_answer;
   assign dm_rvalid = dm_answer_valid;

endmodule

/* File: testbench/memory_space_decoder_asserts.sv */
// Purpose: port-level checks of the memory space decoder
// Assumes: read answers come two edges after the request
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module memory_space_decoder_asserts #(
   parameter integer RAM_SIZE = 4096,
   parameter integer FLASH_SIZE = 65536
) (
   input wire clock,
   input wire reset_n,
   input wire [11:0] rf_addr,
   input wire rf_rd,
   input wire rf_wr,
   input wire [7:0] rf_wdata,
   input wire rf_rvalid,
   input wire ram_rd,
   input wire ram_wr,
   input wire periph_rd,
   input wire periph_wr,
   input wire [15:0] pm_addr,
   input wire [1:0] pm_kind,
   input wire pm_rd,
   input wire [7:0] pm_rdata,
   input wire pm_rvalid,
   input wire flash_rd,
   input wire flash_wr,
   input wire dm_rd,
   input wire dm_rvalid,
   input wire [7:0] dm_rdata,
   input wire info_enabled,
   input wire [7:0] page_select
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence fill_answer;
      pm_rvalid && pm_rdata == 8'hff;
   endsequence
   sequence empty_answer;
      dm_rvalid && dm_rdata == 8'h00;
   endsequence
   a_ram_strobe_gate: assert property (
      ram_rd == (rf_rd && rf_addr < RAM_SIZE && rf_addr < 12'hf00) &&
      ram_wr == (rf_wr && rf_addr < RAM_SIZE && rf_addr < 12'hf00))
      else $error("ram strobe does not follow the request");
   a_periph_window: assert property (
      periph_rd == (rf_rd && rf_addr >= 12'hf00 && rf_addr != 12'hffd))
      else $error("control window strobe wrong");
   a_periph_write_gate: assert property (
      periph_wr == (rf_wr && rf_addr >= 12'hf00 && rf_addr != 12'hffd))
      else $error("control window write strobe wrong");
   a_flash_write_gate: assert property (
      flash_wr |-> pm_addr < FLASH_SIZE && !(info_enabled && pm_addr >= 16'hfe00))
      else $error("flash written outside its range");
   a_fill_beyond_flash: assert property (
      pm_rd && pm_kind == 2'h0 && pm_addr >= FLASH_SIZE |-> ##2 fill_answer)
      else $error("read beyond flash not ff");
   a_fetch_uses_flash: assert property (
      pm_rd && pm_kind == 2'h0 && pm_addr < FLASH_SIZE |-> flash_rd)
      else $error("fetch did not read flash");
   a_overlay_load_read: assert property (
      pm_rd && pm_kind != 2'h0 && info_enabled && pm_addr >= 16'hfe00
      |-> !flash_rd ##2 pm_rvalid)
      else $error("overlay read reached flash");
   a_page_select_write: assert property (
      rf_wr && rf_addr == 12'hffd
      |=> page_select == $past(rf_wdata) && info_enabled == $past(rf_wdata[7]))
      else $error("page select write lost");
   a_data_space_unused: assert property (dm_rd |-> ##2 empty_answer)
      else $error("data space answered");
   a_rf_answer_time: assert property (rf_rd |-> ##2 rf_rvalid)
      else $error("register file answer late");
endmodule

bind memory_space_decoder memory_space_decoder_asserts #(
   .RAM_SIZE(RAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) i_memory_space_decoder_asserts (
   .clock, .reset_n, .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .rf_rvalid, .ram_rd, .ram_wr,
   .periph_rd, .periph_wr, .pm_addr, .pm_kind, .pm_rd, .pm_rdata, .pm_rvalid, .flash_rd,
   .flash_wr,
   .dm_rd, .dm_rvalid, .dm_rdata, .info_enabled, .page_select);

/* File: testbench/mem_model.sv */
// Purpose: byte memory standing behind one decoder port
// Assumes: contents start as a pattern of the address
// Notes: between answers the data flips so a stale byte never passes
`timescale 1ns/1ps
module mem_model #(
   parameter integer AW = 8
) (
   input wire clock,
   input wire [AW-1:0] addr,
   input wire rd,
   input wire wr,
   input wire [7:0] wdata,
   output reg [7:0] rdata
);
   reg [7:0] m [0:(1<<AW)-1];
   integer i;
   initial begin
      rdata = 8'h00;
      for (i = 0; i < (1 << AW); i = i + 1) m[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
   end
   always @(posedge clock) begin
      if (wr) m[addr] <= wdata;
      rdata <= rd ? m[addr] : ~rdata;
   end
endmodule

/* File: testbench/tb.sv */
// Purpose: self-checking bench of the memory space decoder
// Assumes: 2KB ram, 32KB flash so the overlay sits above flash
// Notes: expected bytes queue up per space, a monitor pops them
`timescale 1ns/1ps
module tb;
   // arbitrary part number
   localparam [159:0] pn = {"BENCHID1", 96'h0};
   reg clock = 0, reset_n = 0, rf_rd = 0, rf_wr = 0, pm_rd = 0, pm_wr = 0, dm_rd = 0, dm_wr = 0;
   reg [11:0] rf_addr = 0;
   reg [15:0] pm_addr = 0, dm_addr = 0;
   reg [7:0] rf_wdata = 0, pm_wdata = 0, d;
   reg [1:0] pm_kind = 0;
   wire [11:0] ram_addr;
   wire [15:0] flash_addr;
   wire [7:0] rf_rdata, pm_rdata, dm_rdata, ram_rdata, ram_wdata, periph_addr, periph_rdata;
   wire [7:0] periph_wdata, flash_rdata, flash_wdata, page_select;
   wire rf_rvalid, pm_rvalid, dm_rvalid, ram_rd, ram_wr, periph_rd, periph_wr;
   wire flash_rd, flash_wr, info_enabled;
   integer miscompares = 0, checks = 0, i;
   reg [7:0] rq[$], pq[$], dq[$];
   always #12.5 clock = ~clock;
   memory_space_decoder #(.RAM_SIZE(2048), .FLASH_SIZE(32768), .PART_NUMBER(pn))
   i_memory_space_decoder (.clock, .reset_n, .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .rf_rdata,
      .rf_rvalid, .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata, .periph_addr,
      .periph_rd, .periph_wr, .periph_wdata, .periph_rdata, .pm_addr, .pm_kind, .pm_rd,
      .pm_wr, .pm_wdata, .pm_rdata, .pm_rvalid, .flash_addr, .flash_rd, .flash_wr,
      .flash_wdata, .flash_rdata, .dm_addr, .dm_rd, .dm_wr, .dm_rdata, .dm_rvalid,
      .info_enabled, .page_select);
   mem_model #(.AW(12)) i_mem_model_ram (.clock, .addr(ram_addr), .rd(ram_rd),
      .wr(ram_wr), .wdata(ram_wdata), .rdata(ram_rdata));
   mem_model #(.AW(8)) i_mem_model_periph (.clock, .addr(periph_addr), .rd(periph_rd),
      .wr(periph_wr), .wdata(periph_wdata), .rdata(periph_rdata));
   mem_model #(.AW(16)) i_mem_model_flash (.clock, .addr(flash_addr), .rd(flash_rd),
      .wr(flash_wr), .wdata(flash_wdata), .rdata(flash_rdata));
   function [7:0] pat(input [15:0] a);
      pat = a[7:0] ^ a[15:8] ^ 8'ha5;
   endfunction
   task cmp(input [7:0] e, input [7:0] v);
      begin
         checks = checks + 1;
         if (v !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
         end
      end
   endtask
   // strobes are held to the next negedge so back-to-back calls never clash
   task rf(input w, input [11:0] a, input [7:0] dd, input [7:0] e);
      begin
         @(negedge clock);
         // a request on one bus drops the strobes left standing on the others
         {pm_rd, pm_wr, dm_rd, dm_wr} = 4'h0;
         {rf_rd, rf_wr, rf_addr, rf_wdata} = {!w, w, a, dd};
         if (!w) rq.push_back(e);
      end
   endtask
   task pm(input w, input [1:0] k, input [15:0] a, input [7:0] dd, input [7:0] e);
      begin
         @(negedge clock);
         {rf_rd, rf_wr, dm_rd, dm_wr} = 4'h0;
         {pm_rd, pm_wr, pm_kind, pm_addr, pm_wdata} = {!w, w, k, a, dd};
         if (!w) pq.push_back(e);
      end
   endtask
   task dm(input w, input [15:0] a);
      begin
         @(negedge clock);
         {rf_rd, rf_wr, pm_rd, pm_wr} = 4'h0;
         {dm_rd, dm_wr, dm_addr} = {!w, w, a};
         if (!w) dq.push_back(8'h00);
      end
   endtask
   task fin(input [63:0] n);
      begin
         @(negedge clock);
         {rf_rd, rf_wr, pm_rd, pm_wr, dm_rd, dm_wr} = 6'h00;
         repeat (4) @(negedge clock);
         $display("test %0s done", n);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   always @(negedge clock) begin
      if (rf_rvalid === 1'b1) cmp(rq.pop_front(), rf_rdata);
      if (pm_rvalid === 1'b1) cmp(pq.pop_front(), pm_rdata);
      if (dm_rvalid === 1'b1) cmp(dq.pop_front(), dm_rdata);
   end
   initial begin
      i = $urandom(22);
      repeat (10) @(negedge clock);
      reset_n = 1;
      d = $urandom;
      rf(1, 12'h000, d, 0);
      rf(1, 12'h7ff, ~d, 0);
      rf(0, 12'h000, 0, d);
      rf(0, 12'h7ff, 0, ~d);
      rf(1, 12'h800, d, 0);
      rf(0, 12'h800, 0, 8'h00);
      rf(0, 12'heff, 0, 8'h00);
      cmp(pat(16'h0800), i_mem_model_ram.m[12'h800]);
      rf(0, 12'hf00, 0, pat(16'h0000));
      rf(0, 12'hfff, 0, pat(16'h00ff));
      for (i = 0; i < 8; i = i + 1) begin
         d = $urandom;
         rf(1, 12'h100 + i * 200, d, 0);
         rf(0, 12'h100 + i * 200, 0, d);
      end
      rf(1, 12'hf10, d, 0);
      rf(0, 12'hf10, 0, d);
      rf(1, 12'hffd, 8'h80, 0);
      rf(0, 12'hffd, 0, 8'h80);
      fin("regfile");
      pm(1, 1, 16'h0010, d, 0);
      pm(0, 0, 16'h0010, 0, d);
      pm(0, 1, 16'h7fff, 0, pat(16'h7fff));
      pm(0, 0, 16'h8000, 0, 8'hff);
      pm(1, 1, 16'h8000, d, 0);
      pm(0, 2, 16'h8000, 0, 8'hff);
      cmp(pat(16'h8000), i_mem_model_flash.m[16'h8000]);
      for (i = 0; i < 21; i = i + 1)
         pm(0, 1 + i % 2, 16'hfe40 + i, 0, i < 20 ? pn[159 - 8 * i -: 8] : 8'h00);
      pm(0, 0, 16'hfe40, 0, 8'hff);
      pm(1, 1, 16'hfe40, 8'h00, 0);
      pm(0, 1, 16'hfe40, 0, pn[159 -: 8]);
      fin("overlay");
      cmp(8'h80, page_select);
      cmp(8'h01, {7'h00, info_enabled});
      reset_n = 0;
      repeat (2) @(negedge clock);
      cmp(8'h00, page_select);
      cmp(8'h00, {7'h00, info_enabled});
      reset_n = 1;
      rf(1, 12'hffd, 8'h00, 0);
      pm(0, 1, 16'hfe40, 0, 8'hff);
      dm(1, 16'h1234);
      dm(0, 16'h1234);
      fin("plain");
      cmp(rq.size() + pq.size() + dq.size(), 0);
      summarize;
   end
endmodule
